// >>> rtl/prs_regs.v
/*
 Power management register slice: interrupt enables for three supply events,
 reset cause, memory block status, supply status, deep-off entry,
 power-fail comparator setup and retained scratch.
 Assumes a single-cycle register port, synchronous status inputs, and a
 power-up reset por_i that is asserted only when power is first applied.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "prs_map.vh"
module prs_regs #(
  parameter ADDR_W = 12,
  parameter BLOCKS = 4
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire por_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire pin_reset_flag_i,
  input wire watchdog_reset_flag_i,
  input wire soft_reset_flag_i,
  input wire core_hang_flag_i,
  input wire gpio_wake_flag_i,
  input wire low_power_comparator_wake_flag_i,
  input wire debug_wake_flag_i,
  input wire field_detect_wake_flag_i,
  input wire vbus_wake_flag_i,
  input wire [2*BLOCKS-1:0] mem_sect0_on_i,
  input wire supply_presence_i,
  input wire usb_regulator_settled_i,
  input wire high_voltage_input_only_i,
  input wire supply_attach_event_i,
  input wire supply_removal_event_i,
  input wire usb_supply_ready_event_i,
  output reg supply_attach_irq_o,
  output reg supply_removal_irq_o,
  output reg usb_supply_ready_irq_o,
  output reg deep_off_request_o,
  output reg power_fail_warn_enable_o,
  output reg [3:0] pf_level_code_o,
  output reg pf_level_high_rail_o
);
  localparam RCW = `PRS_RC_WIDTH;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire hit_set = (addr_i == `PRS_OFF_IRQ_EN_SET);
  wire hit_clr = (addr_i == `PRS_OFF_IRQ_EN_CLR);
  wire hit_rc = (addr_i == `PRS_OFF_RESET_CAUSE);
  wire hit_ms = (addr_i == `PRS_OFF_MEM_STATUS);
  wire hit_us = (addr_i == `PRS_OFF_USB_STATUS);
  wire hit_off = (addr_i == `PRS_OFF_DEEP_OFF);
  wire hit_pf = (addr_i == `PRS_OFF_PF_CONFIG);
  wire hit_sc = (addr_i == `PRS_OFF_SCRATCH);
  wire hit_cmp = (addr_i == `PRS_OFF_PF_COMPARE);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables

  reg [2:0] irq_en_q;
  reg [2:0] irq_en_d;
  wire [2:0] wr_bits = {wdata_i[`PRS_IRQ_READY_BIT], wdata_i[`PRS_IRQ_REMOVE_BIT],
    wdata_i[`PRS_IRQ_ATTACH_BIT]};

  always @* begin
    irq_en_d = irq_en_q;
    if (wr_i && hit_set) begin
      irq_en_d = irq_en_q | wr_bits;
    end
    if (wr_i && hit_clr) begin
      irq_en_d = irq_en_q & ~wr_bits;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_q <= 3'h0;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // Gated event pulses, registered so each output comes from a flop
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_attach_irq_o <= 1'b0;
      supply_removal_irq_o <= 1'b0;
      usb_supply_ready_irq_o <= 1'b0;
    end else begin
      supply_attach_irq_o <= supply_attach_event_i & irq_en_q[0];
      supply_removal_irq_o <= supply_removal_event_i & irq_en_q[1];
      usb_supply_ready_irq_o <= usb_supply_ready_event_i & irq_en_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause, on the power-up reset so it survives system resets

  wire [RCW-1:0] cause_set = {vbus_wake_flag_i, field_detect_wake_flag_i, debug_wake_flag_i,
    low_power_comparator_wake_flag_i, gpio_wake_flag_i, core_hang_flag_i, soft_reset_flag_i,
    watchdog_reset_flag_i, pin_reset_flag_i};
  wire [RCW-1:0] cause_clr = {wdata_i[`PRS_RC_VBUS_WAKE:`PRS_RC_GPIO_WAKE],
    wdata_i[`PRS_RC_HANG:`PRS_RC_PIN]};
  wire [RCW-1:0] cause_flags;

  prs_cause_flags #(
    .WIDTH(RCW)
  ) u_cause (
    .ref_clk_i(ref_clk_i),
    .por_i(por_i),
    .cause_set_i(cause_set),
    .clear_en_i(wr_i & hit_rc),
    .clear_mask_i(cause_clr),
    .flags_o(cause_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memory block status

  wire [BLOCKS-1:0] block_on;

  prs_mem_status #(
    .BLOCKS(BLOCKS)
  ) u_mem (
    .sect0_on_i(mem_sect0_on_i),
    .block_on_o(block_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Deep-off request, one-cycle pulse on a write of one

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      deep_off_request_o <= 1'b0;
    end else begin
      deep_off_request_o <= wr_i & hit_off & wdata_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-fail configuration

  reg [11:0] pf_q;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_q <= `PRS_PF_RESET;
    end else if (wr_i && hit_pf) begin
      pf_q <= {wdata_i[`PRS_PF_HV_MSB:`PRS_PF_HV_LSB], 3'h0,
        wdata_i[`PRS_PF_THR_MSB:`PRS_PF_THR_LSB], wdata_i[`PRS_PF_EN_BIT]};
    end
  end

  wire [3:0] main_code = pf_q[`PRS_PF_THR_MSB:`PRS_PF_THR_LSB];
  wire [3:0] hv_code = pf_q[`PRS_PF_HV_MSB:`PRS_PF_HV_LSB];

  // Comparator code: main field in normal mode, high rail field only when
  // the supply feeds the high input alone. Main codes below 4 are passed on
  // unchanged; software is expected to avoid them.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_fail_warn_enable_o <= 1'b0;
      pf_level_code_o <= 4'h0;
      pf_level_high_rail_o <= 1'b0;
    end else begin
      power_fail_warn_enable_o <= pf_q[`PRS_PF_EN_BIT];
      pf_level_high_rail_o <= high_voltage_input_only_i;
      if (high_voltage_input_only_i) begin
        pf_level_code_o <= hv_code;
      end else begin
        pf_level_code_o <= main_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retained scratch, only the power-up reset touches it

  reg [31:0] scratch_q;

  always @(posedge ref_clk_i or posedge por_i) begin
    if (por_i) begin
      scratch_q <= `PRS_SCRATCH_RESET;
    end else if (wr_i && hit_sc) begin
      scratch_q <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped and write-only addresses read zero

  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    if (hit_set || hit_clr) begin
      rd_d[`PRS_IRQ_ATTACH_BIT] = irq_en_q[0];
      rd_d[`PRS_IRQ_REMOVE_BIT] = irq_en_q[1];
      rd_d[`PRS_IRQ_READY_BIT] = irq_en_q[2];
    end else if (hit_rc) begin
      rd_d[`PRS_RC_HANG:`PRS_RC_PIN] = cause_flags[3:0];
      rd_d[`PRS_RC_VBUS_WAKE:`PRS_RC_GPIO_WAKE] = cause_flags[RCW-1:4];
    end else if (hit_ms) begin
      rd_d[BLOCKS-1:0] = block_on;
    end else if (hit_us) begin
      rd_d[`PRS_US_PRESENCE_BIT] = supply_presence_i;
      rd_d[`PRS_US_SETTLED_BIT] = usb_regulator_settled_i;
    end else if (hit_pf) begin
      rd_d[11:0] = pf_q;
    end else if (hit_sc) begin
      rd_d = scratch_q;
    end else if (hit_cmp) begin
      rd_d[3:0] = (high_voltage_input_only_i) ? hv_code : main_code;
      rd_d[4] = high_voltage_input_only_i;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      rdata_o <= rd_d;
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule // prs_regs

// >>> rtl/prs_map.vh
/*
 Register offsets, field positions and reset values of the power and reset status slice.
 Assumes byte addresses on a 12-bit register port.
*/
`ifndef PRS_MAP_VH
`define PRS_MAP_VH
`define PRS_OFF_IRQ_EN_SET 12'h304
`define PRS_OFF_IRQ_EN_CLR 12'h308
`define PRS_OFF_RESET_CAUSE 12'h400
`define PRS_OFF_MEM_STATUS 12'h428
`define PRS_OFF_USB_STATUS 12'h438
`define PRS_OFF_DEEP_OFF 12'h500
`define PRS_OFF_PF_CONFIG 12'h510
`define PRS_OFF_SCRATCH 12'h51c
`define PRS_OFF_PF_COMPARE 12'h600
`define PRS_IRQ_ATTACH_BIT 7
`define PRS_IRQ_REMOVE_BIT 8
`define PRS_IRQ_READY_BIT 9
`define PRS_RC_WIDTH 9
`define PRS_RC_PIN 0
`define PRS_RC_DOG 1
`define PRS_RC_SOFT 2
`define PRS_RC_HANG 3
`define PRS_RC_GPIO_WAKE 16
`define PRS_RC_VBUS_WAKE 20
`define PRS_PF_EN_BIT 0
`define PRS_PF_THR_LSB 1
`define PRS_PF_THR_MSB 4
`define PRS_PF_HV_LSB 8
`define PRS_PF_HV_MSB 11
`define PRS_PF_RESET 12'h000
`define PRS_US_PRESENCE_BIT 0
`define PRS_US_SETTLED_BIT 1
`define PRS_SCRATCH_RESET 32'h00000000
`define PRS_THR_MIN_CODE 4'h4
`endif

// >>> rtl/prs_cause_flags.v
/*
 Sticky reset cause flags, accumulating across resets.
 Assumes it sits on the always-on power-up reset, not on the system reset,
 and that cause pulses are one cycle wide and synchronous.
*/
`timescale 1ns/100ps
module prs_cause_flags #(
  parameter WIDTH = 9
) (
  input wire ref_clk_i,
  input wire por_i,
  input wire [WIDTH-1:0] cause_set_i,
  input wire clear_en_i,
  input wire [WIDTH-1:0] clear_mask_i,
  output wire [WIDTH-1:0] flags_o
);
  reg [WIDTH-1:0] flags_q;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_flag
      // Set wins over a same-cycle clear
      always @(posedge ref_clk_i or posedge por_i) begin
        if (por_i) begin
          flags_q[g] <= 1'b0;
        end else if (cause_set_i[g]) begin
          flags_q[g] <= 1'b1;
        end else if (clear_en_i && clear_mask_i[g]) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign flags_o = flags_q;
endmodule // prs_cause_flags

// >>> rtl/prs_mem_status.v
/*
 Folds per-macro section 0 power states into four block bits.
 Assumes section power inputs are synchronous levels.
*/
`timescale 1ns/100ps
module prs_mem_status #(
  parameter BLOCKS = 4
) (
  input wire [2*BLOCKS-1:0] sect0_on_i,
  output wire [BLOCKS-1:0] block_on_o
);
  genvar k;
  generate
    for (k = 0; k < BLOCKS; k = k + 1) begin : g_blk
      assign block_on_o[k] = sect0_on_i[2*k] | sect0_on_i[2*k+1];
    end
  endgenerate
endmodule // prs_mem_status

// >>> test/prs_regs_assertions.sv
/* Checker for the power and reset status slice.
   Assumes binding to prs_regs with its default 12-bit address and four blocks. */
`timescale 1ns/100ps
`include "prs_map.vh"
module prs_regs_assertions (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [11:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire [7:0] mem_sect0_on_i,
  input wire supply_presence_i,
  input wire usb_regulator_settled_i,
  input wire high_voltage_input_only_i,
  input wire supply_attach_event_i,
  input wire supply_attach_irq_o,
  input wire deep_off_request_o,
  input wire power_fail_warn_enable_o,
  input wire [3:0] pf_level_code_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  wire pf_wr = wr_i && addr_i == `PRS_OFF_PF_CONFIG;
  wire off_wr = wr_i && addr_i == `PRS_OFF_DEEP_OFF && wdata_i[0];
  wire clr_wr = wr_i && addr_i == `PRS_OFF_IRQ_EN_CLR && wdata_i[7];
  wire hv = high_voltage_input_only_i;
  wire [7:0] m = mem_sect0_on_i;
  // Two-cycle windows accept either output register placement
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not idle");
  a_deep_off_pulse: assert property (off_wr |=> deep_off_request_o)
    else $error("no deep-off pulse");
  a_irq_cause: assert property (supply_attach_irq_o |-> $past(supply_attach_event_i))
    else $error("attach irq without event");
  a_irq_cleared: assert property (clr_wr ##1 1 |=> !supply_attach_irq_o)
    else $error("attach irq after disable");
  a_pf_enable: assert property (pf_wr ##1 !pf_wr |=>
    power_fail_warn_enable_o == $past(wdata_i[0], 2)) else $error("enable mismatch");
  a_main_level: assert property ((pf_wr && !hv) ##1 (!pf_wr && !hv) |=>
    pf_level_code_o == $past(wdata_i[4:1], 2)) else $error("main level mismatch");
  a_high_level: assert property ((pf_wr && hv) ##1 (!pf_wr && hv) |=>
    pf_level_code_o == $past(wdata_i[11:8], 2)) else $error("high level mismatch");
  a_mem_status: assert property (rd_i && addr_i == `PRS_OFF_MEM_STATUS |=>
    rdata_o == {28'h0, $past({m[7] | m[6], m[5] | m[4], m[3] | m[2], m[1] | m[0]})})
    else $error("block status mismatch");
  a_usb_status: assert property (rd_i && addr_i == `PRS_OFF_USB_STATUS |=>
    rdata_o == {30'h0, $past({usb_regulator_settled_i, supply_presence_i})})
    else $error("supply status mismatch");
endmodule // prs_regs_assertions
bind prs_regs prs_regs_assertions u_chk (.*);

// >>> test/prs_regs_tb.sv
/* Directed register tests for prs_regs.
   Assumes the default 12-bit address and four memory blocks. */
`timescale 1ns/100ps
`include "prs_map.vh"
module prs_regs_tb;
  reg ref_clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  reg [11:0] addr_i = 12'h0;
  reg [31:0] wdata_i = 32'h0;
  reg [7:0] mem_sect0_on_i = 8'h0;
  reg supply_presence_i = 1'b0, usb_regulator_settled_i = 1'b0;
  reg high_voltage_input_only_i = 1'b0;
  reg [8:0] cause = 9'h0;
  reg [2:0] ev = 3'h0;
  wire [31:0] rdata_o;
  wire [2:0] irq;
  wire deep_off_request_o, power_fail_warn_enable_o, pf_level_high_rail_o;
  wire [3:0] pf_level_code_o;
  integer num_errors = 0, samples_checked = 0, offs = 0, i;
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (deep_off_request_o === 1'b1) offs = offs + 1;
  prs_regs u_dut (.*, .pin_reset_flag_i(cause[0]), .watchdog_reset_flag_i(cause[1]),
    .soft_reset_flag_i(cause[2]), .core_hang_flag_i(cause[3]), .gpio_wake_flag_i(cause[4]),
    .low_power_comparator_wake_flag_i(cause[5]), .debug_wake_flag_i(cause[6]),
    .field_detect_wake_flag_i(cause[7]), .vbus_wake_flag_i(cause[8]),
    .supply_attach_event_i(ev[0]), .supply_removal_event_i(ev[1]),
    .usb_supply_ready_event_i(ev[2]), .supply_attach_irq_o(irq[0]),
    .supply_removal_irq_o(irq[1]), .usb_supply_ready_irq_o(irq[2]));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // Read data stand one cycle only, so they are sampled just after that edge
  task rd(input [11:0] a, input [31:0] e);
    begin
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
    end
  endtask
  task pulse_ev(input [2:0] e, input [2:0] x);
    begin
      @(posedge ref_clk_i);
      ev <= e;
      @(posedge ref_clk_i);
      ev <= 3'h0;
      #1 chk({29'h0, irq}, {29'h0, x});
    end
  endtask
  // Three edges after a mode change allow for the registered level view
  task pf_chk(input h, input [5:0] x);
    begin
      @(posedge ref_clk_i);
      high_voltage_input_only_i <= h;
      repeat (3) @(posedge ref_clk_i);
      #1 chk({26'h0, pf_level_high_rail_o, power_fail_warn_enable_o, pf_level_code_o}, x);
    end
  endtask
  task stop_test;
    begin
      $display("Checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    num_errors = num_errors + 1;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(`PRS_OFF_RESET_CAUSE, 32'h0);
    rd(`PRS_OFF_DEEP_OFF, 32'h0);
    rd(12'h7fc, 32'h0);
    $display("Test reset values done");
    wr(`PRS_OFF_IRQ_EN_SET, 32'h380);
    rd(`PRS_OFF_IRQ_EN_CLR, 32'h380);
    pulse_ev(3'h7, 3'h7);
    wr(`PRS_OFF_IRQ_EN_CLR, 32'h0);
    wr(`PRS_OFF_IRQ_EN_CLR, 32'h80);
    rd(`PRS_OFF_IRQ_EN_CLR, 32'h300);
    pulse_ev(3'h7, 3'h6);
    $display("Test interrupt enables done");
    for (i = 0; i < 9; i = i + 1) begin
      @(posedge ref_clk_i);
      cause <= 9'h1 << i;
    end
    @(posedge ref_clk_i);
    cause <= 9'h0;
    rd(`PRS_OFF_RESET_CAUSE, 32'h1f000f);
    wr(`PRS_OFF_SCRATCH, 32'ha5a55a5a);
    wr(`PRS_OFF_PF_CONFIG, 32'h00000f1f);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(`PRS_OFF_RESET_CAUSE, 32'h1f000f);
    rd(`PRS_OFF_SCRATCH, 32'ha5a55a5a);
    rd(`PRS_OFF_PF_CONFIG, 32'h0);
    rd(`PRS_OFF_IRQ_EN_CLR, 32'h0);
    wr(`PRS_OFF_RESET_CAUSE, 32'h0);
    wr(`PRS_OFF_RESET_CAUSE, 32'h1);
    rd(`PRS_OFF_RESET_CAUSE, 32'h1f000e);
    wr(`PRS_OFF_RESET_CAUSE, 32'h1f000e);
    rd(`PRS_OFF_RESET_CAUSE, 32'h0);
    $display("Test reset cause done");
    // Main codes stay at 4 and above; lower codes would trip brownout first
    wr(`PRS_OFF_PF_CONFIG, 32'hffffffff);
    rd(`PRS_OFF_PF_CONFIG, 32'h00000f1f);
    wr(`PRS_OFF_PF_CONFIG, 32'h00000a13);
    pf_chk(1'b0, 6'h19);
    pf_chk(1'b1, 6'h3a);
    rd(`PRS_OFF_PF_COMPARE, 32'h1a);
    wr(`PRS_OFF_PF_CONFIG, 32'h00000008);
    pf_chk(1'b0, 6'h04);
    rd(`PRS_OFF_PF_COMPARE, 32'h4);
    $display("Test power-fail config done");
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge ref_clk_i);
      mem_sect0_on_i <= 8'h1 << i;
      rd(`PRS_OFF_MEM_STATUS, 32'h1 << (i / 2));
    end
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge ref_clk_i);
      {usb_regulator_settled_i, supply_presence_i} <= i[1:0];
      rd(`PRS_OFF_USB_STATUS, i);
    end
    wr(`PRS_OFF_DEEP_OFF, 32'h0);
    wr(`PRS_OFF_DEEP_OFF, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk(offs, 32'h1);
    $display("Test status and deep-off done");
    stop_test;
  end
endmodule // prs_regs_tb
